// [rtl/gcw_pkg.sv]
// gcw_pkg: constants and carrier types for the control word selector
// assumes: included ahead of all gcw design files
package gcw_pkg;
	localparam int          WORD_W          = 16;
	localparam int          ADDR_W          = 16;
	localparam int          NODE_W          = 7;
	localparam int          IDX_W           = 5;
	localparam int          GTAB_WORDS      = 32;
	// register numbers as seen on the network
	localparam logic [15:0] REG_CTRL        = 16'h9C41;
	localparam logic [15:0] REG_REF         = 16'h9C42;
	localparam logic [15:0] REG_RO_FIRST    = 16'h9C4B;
	localparam logic [15:0] REG_RO_LAST     = 16'h9CA4;
	localparam logic [15:0] REG_PARAM_BASE  = 16'h9CA5;
	localparam logic [15:0] REG_PARAM_ONE   = 16'h0001;
	localparam logic [3:0]  PATH_MIN        = 4'h1;
	localparam logic [3:0]  PATH_MAX        = 4'h8;
	localparam logic [NODE_W-1:0] GROUP_SIZE = 7'h10;
	localparam logic [15:0] WORD_RESET      = 16'h0000;
	// status codes
	localparam logic [7:0]  ERR_NONE        = 8'h00;
	localparam logic [7:0]  ERR_READ_ONLY   = 8'h01;
	localparam logic [7:0]  ERR_BAD_PATH    = 8'h02;
	localparam logic [7:0]  ERR_BAD_REG     = 8'h03;

	typedef struct packed {
		logic [15:0] reg_num;
		logic [3:0]  path;
		logic [15:0] data;
	} gcw_wr_t;

	typedef struct packed {
		logic [NODE_W-1:0] src_node;
		logic [IDX_W-1:0]  index;
		logic [15:0]       data;
	} gcw_glob_t;
endpackage : gcw_pkg

// [rtl/gcw_slot_index.sv]
// gcw_slot_index: global table slot from node address
// assumes: node address is static configuration, values 1 to 64
`timescale 1ns/10ps
module gcw_slot_index (
	input  wire logic [gcw_pkg::NODE_W-1:0] NODE_ADDR,
	output logic      [gcw_pkg::IDX_W-1:0]  CTRL_IDX,
	output logic      [gcw_pkg::IDX_W-1:0]  REF_IDX
);
	logic [gcw_pkg::NODE_W-1:0] rel;

	// groups start at 1, 17, 33, 49; offset within group times two
	assign rel      = NODE_ADDR - 7'h01;
	assign CTRL_IDX = {rel[3:0], 1'b0};
	assign REF_IDX  = {rel[3:0], 1'b1};
endmodule : gcw_slot_index

// [rtl/gcw_select.sv]
// gcw_select: picks drive control and reference words from global data or writes
// assumes: inputs are produced by network logic on CLK; config switches are pins
// Behaviour
// - global mode takes words from host broadcast
// - slot index is twice address offset in group
// - even index control, next index reference
// - accept broadcast only from configured host node
// - take only own two slot words
// - normal mode ignores broadcast table
// - writes to read-only range give error code
// - routing path must lie in 1 to 8
// - parameter register write updates drive parameter
// - write answers and status unaffected by control mode
// - parameter space begins at parameter one
`timescale 1ns/10ps
module gcw_select (
	input  wire logic                        CLK,
	input  wire logic                        ARST_N,
	input  wire logic                        GLOBAL_MODE,
	input  wire logic [gcw_pkg::NODE_W-1:0]  NODE_ADDR,
	input  wire logic [gcw_pkg::NODE_W-1:0]  HOST_NODE,
	input  wire logic                        WR_VALID,
	input  wire gcw_pkg::gcw_wr_t            WR,
	input  wire logic                        GLOB_VALID,
	input  wire gcw_pkg::gcw_glob_t          GLOB,
	output logic      [15:0]                 CTRL_WORD,
	output logic      [15:0]                 REF_WORD,
	output logic                             WR_DONE,
	output logic                             WR_FAIL,
	output logic      [7:0]                  ERR_CODE,
	output logic                             PARAM_WR,
	output logic      [15:0]                 PARAM_NUM,
	output logic      [15:0]                 PARAM_DATA
);
	logic [1:0]                 mode_sync;
	logic [gcw_pkg::NODE_W-1:0] node_s1;
	logic [gcw_pkg::NODE_W-1:0] node_s2;
	logic [gcw_pkg::NODE_W-1:0] host_s1;
	logic [gcw_pkg::NODE_W-1:0] host_s2;
	logic [gcw_pkg::IDX_W-1:0]  ctrl_idx;
	logic [gcw_pkg::IDX_W-1:0]  ref_idx;
	logic                       mode;
	logic                       path_ok;
	logic                       is_ro;
	logic                       is_param;
	logic                       is_ctrl;
	logic                       is_ref;
	logic                       src_ok;

	// configuration switches pass two flip-flops
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mode_sync <= 2'h0;
			node_s1   <= 7'h00;
			node_s2   <= 7'h00;
			host_s1   <= 7'h00;
			host_s2   <= 7'h00;
		end else begin
			mode_sync <= {mode_sync[0], GLOBAL_MODE};
			node_s1   <= NODE_ADDR;
			node_s2   <= node_s1;
			host_s1   <= HOST_NODE;
			host_s2   <= host_s1;
		end
	end
	assign mode = mode_sync[1];

	gcw_slot_index u_slot (
		.NODE_ADDR (node_s2),
		.CTRL_IDX  (ctrl_idx),
		.REF_IDX   (ref_idx)
	);

	// directed write decode
	assign path_ok  = (WR.path >= gcw_pkg::PATH_MIN) && (WR.path <= gcw_pkg::PATH_MAX);
	assign is_ro    = (WR.reg_num >= gcw_pkg::REG_RO_FIRST)
	               && (WR.reg_num <= gcw_pkg::REG_RO_LAST);
	assign is_param = WR.reg_num >= gcw_pkg::REG_PARAM_BASE;
	assign is_ctrl  = WR.reg_num == gcw_pkg::REG_CTRL;
	assign is_ref   = WR.reg_num == gcw_pkg::REG_REF;
	assign src_ok   = GLOB.src_node == host_s2;

	// control and reference words
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			CTRL_WORD <= gcw_pkg::WORD_RESET;
			REF_WORD  <= gcw_pkg::WORD_RESET;
		end else if (mode) begin
			// broadcast from wrong source leaves words alone
			if (GLOB_VALID && src_ok) begin
				if (GLOB.index == ctrl_idx)
					CTRL_WORD <= GLOB.data;
				if (GLOB.index == ref_idx)
					REF_WORD  <= GLOB.data;
			end
		end else if (WR_VALID && path_ok) begin
			if (is_ctrl)
				CTRL_WORD <= WR.data;
			if (is_ref)
				REF_WORD  <= WR.data;
		end
	end

	// write answer and status code
	// status does not depend on control mode
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			WR_DONE  <= 1'b0;
			WR_FAIL  <= 1'b0;
			ERR_CODE <= gcw_pkg::ERR_NONE;
		end else begin
			WR_DONE <= WR_VALID;
			WR_FAIL <= 1'b0;
			if (WR_VALID) begin
				if (!path_ok) begin
					WR_FAIL  <= 1'b1;
					ERR_CODE <= gcw_pkg::ERR_BAD_PATH;
				end else if (is_ro) begin
					WR_FAIL  <= 1'b1;
					ERR_CODE <= gcw_pkg::ERR_READ_ONLY;
				end else if (!(is_ctrl || is_ref || is_param)) begin
					WR_FAIL  <= 1'b1;
					ERR_CODE <= gcw_pkg::ERR_BAD_REG;
				end else begin
					ERR_CODE <= gcw_pkg::ERR_NONE;
				end
			end
		end
	end

	// parameter writes pass to the drive
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PARAM_WR   <= 1'b0;
			PARAM_NUM  <= 16'h0000;
			PARAM_DATA <= 16'h0000;
		end else begin
			PARAM_WR <= WR_VALID && path_ok && is_param;
			if (WR_VALID && path_ok && is_param) begin
				PARAM_NUM  <= WR.reg_num - gcw_pkg::REG_PARAM_BASE
				            + gcw_pkg::REG_PARAM_ONE;
				PARAM_DATA <= WR.data;
			end
		end
	end

	AST_BAD_PATH_FAILS: assert property (@(posedge CLK) disable iff (!ARST_N)
		WR_VALID && !path_ok |=> WR_FAIL && ERR_CODE == gcw_pkg::ERR_BAD_PATH)
		else $error("bad path not failed");

	AST_RO_ERROR: assert property (@(posedge CLK) disable iff (!ARST_N)
		WR_VALID && path_ok && is_ro |=> WR_FAIL && ERR_CODE == gcw_pkg::ERR_READ_ONLY
		&& !PARAM_WR)
		else $error("read-only write not flagged");

	AST_PARAM_MAP: assert property (@(posedge CLK) disable iff (!ARST_N)
		WR_VALID && path_ok && WR.reg_num == 16'h9CB7 |=> PARAM_WR && PARAM_NUM == 16'h0013)
		else $error("parameter number mapping wrong");

	AST_PARAM_FIRST: assert property (@(posedge CLK) disable iff (!ARST_N)
		WR_VALID && path_ok && WR.reg_num == gcw_pkg::REG_PARAM_BASE |=> PARAM_NUM == 16'h0001)
		else $error("parameter space base wrong");

	AST_SRC_REJECT: assert property (@(posedge CLK) disable iff (!ARST_N)
		mode && GLOB_VALID && !src_ok |=> $stable(CTRL_WORD) && $stable(REF_WORD))
		else $error("foreign broadcast changed words");

	AST_GLOB_CTRL: assert property (@(posedge CLK) disable iff (!ARST_N)
		mode && GLOB_VALID && src_ok && GLOB.index == {node_s2[3:0] - 4'h1, 1'b0}
		|=> CTRL_WORD == $past(GLOB.data))
		else $error("control word not taken from slot");

	AST_GLOB_REF: assert property (@(posedge CLK) disable iff (!ARST_N)
		mode && GLOB_VALID && src_ok && GLOB.index == {node_s2[3:0] - 4'h1, 1'b1}
		|=> REF_WORD == $past(GLOB.data))
		else $error("reference word not taken from slot");

	AST_NORMAL_IGNORES: assert property (@(posedge CLK) disable iff (!ARST_N)
		!mode && !WR_VALID |=> $stable(CTRL_WORD) && $stable(REF_WORD))
		else $error("broadcast used outside global mode");

	AST_GLOBAL_NO_WRITE: assert property (@(posedge CLK) disable iff (!ARST_N)
		mode && !GLOB_VALID |=> $stable(CTRL_WORD) && $stable(REF_WORD))
		else $error("words changed without broadcast");

	AST_DONE_FOLLOWS: assert property (@(posedge CLK) disable iff (!ARST_N)
		WR_VALID |=> WR_DONE)
		else $error("write not answered");

	AST_DONE_PULSE: assert property (@(posedge CLK) disable iff (!ARST_N)
		!WR_VALID |=> !WR_DONE && !WR_FAIL && !PARAM_WR)
		else $error("answer without write");

	AST_FAIL_WITH_DONE: assert property (@(posedge CLK) disable iff (!ARST_N)
		WR_FAIL |-> WR_DONE)
		else $error("fail without done");

	AST_BAD_REG: assert property (@(posedge CLK) disable iff (!ARST_N)
		WR_VALID && path_ok && (WR.reg_num < gcw_pkg::REG_CTRL
		|| (WR.reg_num > gcw_pkg::REG_REF && WR.reg_num < gcw_pkg::REG_RO_FIRST))
		|=> WR_FAIL && ERR_CODE == gcw_pkg::ERR_BAD_REG)
		else $error("unmapped write not flagged");

	AST_CTRL_WRITE: assert property (@(posedge CLK) disable iff (!ARST_N)
		!mode && WR_VALID && path_ok && WR.reg_num == gcw_pkg::REG_CTRL
		|=> CTRL_WORD == $past(WR.data))
		else $error("control word write not applied");

	AST_REF_WRITE: assert property (@(posedge CLK) disable iff (!ARST_N)
		!mode && WR_VALID && path_ok && WR.reg_num == gcw_pkg::REG_REF
		|=> REF_WORD == $past(WR.data))
		else $error("reference word write not applied");

	AST_BAD_PATH_KEEPS: assert property (@(posedge CLK) disable iff (!ARST_N)
		WR_VALID && !path_ok && !GLOB_VALID
		|=> !PARAM_WR && $stable(CTRL_WORD) && $stable(REF_WORD))
		else $error("bad path write applied");

	AST_RO_KEEPS: assert property (@(posedge CLK) disable iff (!ARST_N)
		WR_VALID && is_ro && !GLOB_VALID |=> $stable(CTRL_WORD) && $stable(REF_WORD))
		else $error("read-only write applied");

	AST_PARAM_DATA: assert property (@(posedge CLK) disable iff (!ARST_N)
		WR_VALID && path_ok && WR.reg_num >= gcw_pkg::REG_PARAM_BASE
		|=> PARAM_WR && PARAM_DATA == $past(WR.data))
		else $error("parameter data not passed");

	AST_GLOB_OTHER_SLOT: assert property (@(posedge CLK) disable iff (!ARST_N)
		mode && GLOB_VALID && GLOB.index[4:1] != node_s2[3:0] - 4'h1
		|=> $stable(CTRL_WORD) && $stable(REF_WORD))
		else $error("foreign slot word taken");
endmodule : gcw_select

// [tb/gcw_host_model.sv]
// gcw_host_model: host controller issuing directed writes and global broadcasts
// assumes: tasks are called by the bench; CLK is the block clock
`timescale 1ns/10ps
module gcw_host_model (
	output logic               WR_VALID,
	output gcw_pkg::gcw_wr_t   WR,
	output logic               GLOB_VALID,
	output gcw_pkg::gcw_glob_t GLOB,
	input  wire logic          CLK
);
	initial begin
		WR_VALID = 1'b0;
		WR = '0;
		GLOB_VALID = 1'b0;
		GLOB = '0;
	end
	// one directed write; released bus shows inverted data
	task automatic wr(input logic [15:0] r, input logic [3:0] p, input logic [15:0] d);
		@(posedge CLK) #1;
		WR_VALID = 1'b1;
		WR = '{r, p, d};
		@(posedge CLK) #1;
		WR_VALID = 1'b0;
		WR = ~WR;
	endtask : wr
	// full global table, words back to back
	task automatic pkt(input logic [6:0] s, input logic [15:0] b);
		for (int i = 0; i < gcw_pkg::GTAB_WORDS; i++) begin
			@(posedge CLK) #1;
			GLOB_VALID = 1'b1;
			GLOB = '{s, i[4:0], b + 16'(i)};
		end
		@(posedge CLK) #1;
		GLOB_VALID = 1'b0;
		GLOB = ~GLOB;
	endtask : pkt
endmodule : gcw_host_model

// [tb/gcw_select_bench.sv]
// gcw_select_bench: self-checking bench for the control word selector
// assumes: gcw_pkg, gcw_select and gcw_host_model compiled first
`timescale 1ns/10ps
module gcw_select_bench;
	typedef struct packed {
		logic [15:0] r;
		logic [3:0]  p;
		logic [7:0]  e;
		logic        w;
	} gcw_row_t;
	logic               CLK, ARST_N, GLOBAL_MODE, WR_VALID, GLOB_VALID, WR_DONE, WR_FAIL, PARAM_WR;
	logic [6:0]         NODE_ADDR, HOST_NODE;
	gcw_pkg::gcw_wr_t   WR;
	gcw_pkg::gcw_glob_t GLOB;
	logic [15:0]        CTRL_WORD, REF_WORD, PARAM_NUM, PARAM_DATA, ec, er, d;
	logic [7:0]         ERR_CODE;
	int                 bad_count = 0;
	int                 checks_done = 0;
	gcw_row_t rows [9] = '{'{16'h9C41, 4'h1, 8'h00, 1'b0}, '{16'h9C42, 4'h8, 8'h00, 1'b0},
		'{16'h9CB7, 4'h1, 8'h00, 1'b1}, '{16'h9CA5, 4'h2, 8'h00, 1'b1},
		'{16'h9C4B, 4'h1, 8'h01, 1'b0}, '{16'h9CA4, 4'h1, 8'h01, 1'b0},
		'{16'h9C41, 4'h0, 8'h02, 1'b0}, '{16'h9C41, 4'h9, 8'h02, 1'b0},
		'{16'h9C45, 4'h1, 8'h03, 1'b0}};
	logic [6:0] adr [9] = '{7'h01, 7'h10, 7'h11, 7'h20, 7'h21, 7'h25, 7'h30, 7'h31, 7'h40};
	gcw_host_model i_host (.CLK(CLK), .WR_VALID(WR_VALID), .WR(WR), .GLOB_VALID(GLOB_VALID),
		.GLOB(GLOB));
	gcw_select i_dut (.CLK(CLK), .ARST_N(ARST_N), .GLOBAL_MODE(GLOBAL_MODE), .NODE_ADDR(NODE_ADDR),
		.HOST_NODE(HOST_NODE), .WR_VALID(WR_VALID), .WR(WR), .GLOB_VALID(GLOB_VALID), .GLOB(GLOB),
		.CTRL_WORD(CTRL_WORD), .REF_WORD(REF_WORD), .WR_DONE(WR_DONE), .WR_FAIL(WR_FAIL),
		.ERR_CODE(ERR_CODE), .PARAM_WR(PARAM_WR), .PARAM_NUM(PARAM_NUM), .PARAM_DATA(PARAM_DATA));
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
		checks_done++;
		if (s !== x) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	initial begin
		#10000;
		bad_count++;
		final_report();
	end
	initial begin
		ARST_N = 1'b0;
		GLOBAL_MODE = 1'b0;
		NODE_ADDR = 7'h25;
		HOST_NODE = 7'h05;
		ec = 16'h0000;
		er = 16'h0000;
		repeat (4) @(posedge CLK);
		#1 ARST_N = 1'b1;
		repeat (3) @(posedge CLK);
		for (int k = 0; k < 9; k++) begin
			d = 16'h5A00 + 16'(k);
			i_host.wr(rows[k].r, rows[k].p, d);
			if (rows[k].e == 8'h00 && rows[k].r == gcw_pkg::REG_CTRL) ec = d;
			if (rows[k].e == 8'h00 && rows[k].r == gcw_pkg::REG_REF) er = d;
			chk("done", WR_DONE, 16'h0001);
			chk("fail", WR_FAIL, 16'(rows[k].e != 8'h00));
			chk("err", ERR_CODE, rows[k].e);
			chk("pwr", PARAM_WR, rows[k].w);
			if (rows[k].w) chk("pnum", PARAM_NUM, rows[k].r - 16'h9CA4);
			if (rows[k].w) chk("pdat", PARAM_DATA, d);
			chk("ctrl", CTRL_WORD, ec);
			chk("ref", REF_WORD, er);
		end
		$display("test table done");
		GLOBAL_MODE = 1'b1;
		foreach (adr[j]) begin
			NODE_ADDR = adr[j];
			repeat (4) @(posedge CLK);
			d = {4'hA, 4'(j), 8'h00};
			i_host.pkt(7'h05, d);
			ec = d + 16'({(adr[j] - 7'h01) & 7'h0F, 1'b0});
			er = ec + 16'h0001;
			chk("gctrl", CTRL_WORD, ec);
			chk("gref", REF_WORD, er);
		end
		i_host.pkt(7'h06, 16'hB000);
		chk("src", CTRL_WORD, ec);
		chk("srcr", REF_WORD, er);
		i_host.wr(gcw_pkg::REG_CTRL, 4'h1, 16'hC0DE);
		chk("gwr", CTRL_WORD, ec);
		chk("gerr", ERR_CODE, 8'h00);
		$display("test global done");
		GLOBAL_MODE = 1'b0;
		repeat (4) @(posedge CLK);
		i_host.pkt(7'h05, 16'hD000);
		chk("nctrl", CTRL_WORD, ec);
		chk("nref", REF_WORD, er);
		$display("test normal done");
		ARST_N = 1'b0;
		#1 chk("rctrl", CTRL_WORD, 16'h0000);
		chk("rref", REF_WORD, 16'h0000);
		chk("rerr", ERR_CODE, 16'h0000);
		chk("rpnum", PARAM_NUM, 16'h0000);
		@(posedge CLK) #1 ARST_N = 1'b1;
		repeat (3) @(posedge CLK);
		i_host.wr(gcw_pkg::REG_REF, 4'h1, 16'h1234);
		chk("pdone", WR_DONE, 16'h0001);
		chk("pref", REF_WORD, 16'h1234);
		$display("test reset done");
		final_report();
	end
endmodule : gcw_select_bench
